// ===== pkg/prdly_map.vh
// Register map, field positions, reset values and timing counts
// Assumes a 32-bit APB slave and a 20 MHz mclk
// Overview of operation
// - Comparator sync delays shutdown until first timer
// - Auto restart clears event flag when cause gone
// - Without auto restart software clears event flag
// - Active edge delayed by count instruction cycles
// - Restart and delay bits reset to zero
// - Event flag set holds outputs in shutdown
// - Three-bit code selects shutdown sources
// - Shutdown pair drive low, high or tristate
`ifndef PRDLY_MAP_VH
`define PRDLY_MAP_VH
// Register byte offsets
`define PRDLY_OFS_DELAY_CTRL 12'h000
`define PRDLY_OFS_SHUTDOWN_CTRL 12'h004
`define PRDLY_OFS_STATUS 12'h008
// Delay control fields
`define PRDLY_RESTART_BIT 7
`define PRDLY_COUNT_MSB 6
`define PRDLY_DELAY_CTRL_RESET 8'h00
// Shutdown control fields
`define PRDLY_FLAG_BIT 7
`define PRDLY_SRC_MSB 6
`define PRDLY_SRC_LSB 4
`define PRDLY_AC_MSB 3
`define PRDLY_AC_LSB 2
`define PRDLY_BD_MSB 1
`define PRDLY_BD_LSB 0
`define PRDLY_SHUTDOWN_CTRL_RESET 8'h00
// Instruction cycle is four oscillator periods
`define PRDLY_OSC_PER_INSTR 2'h3
`endif

// ===== rtl/prdly_source_sel.v
// Shutdown source decoder
// Assumes comparator and pin inputs already synchronous to mclk
`timescale 1ns/1ns
`default_nettype none
module prdly_source_sel
(
  // Selection
  input wire [2:0] sel,
  // Sources
  input wire cmp1_high,
  input wire cmp2_high,
  input wire int_pin_low,
  // Result
  output reg cause
);
  // Decode three-bit code; 000 disables
  always @*
  begin
    case (sel)
      3'h0: cause = 1'b0;
      3'h1: cause = cmp1_high;
      3'h2: cause = cmp2_high;
      3'h3: cause = cmp1_high | cmp2_high;
      3'h4: cause = int_pin_low;
      3'h5: cause = int_pin_low | cmp1_high;
      3'h6: cause = int_pin_low | cmp2_high;
      default: cause = int_pin_low | cmp1_high | cmp2_high;
    endcase
  end
endmodule // prdly_source_sel
`default_nettype wire

// ===== rtl/prdly_edge_delay.v
// One-channel active-edge delay
// Assumes instr_tick pulses once per instruction cycle
`timescale 1ns/1ns
`default_nettype none
module prdly_edge_delay
(
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Control
  input wire [6:0] count,
  input wire instr_tick,
  // Waveform
  input wire sched,
  output reg out
);
  reg [6:0] remain; // Instruction cycles left
  reg sched_q; // Previous scheduled level
  // Delay rising edges only
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      remain <= 7'h00;
      sched_q <= 1'b0;
      out <= 1'b0;
    end
    else
    begin
      sched_q <= sched;
      if (!sched)
      begin
        // Falling edge passes unchanged
        out <= 1'b0;
        remain <= 7'h00;
      end
      else if (!sched_q)
      begin
        // New active request; zero count is immediate
        if (count == 7'h00)
          out <= 1'b1;
        else
          remain <= count;
      end
      else if (!out && remain != 7'h00 && instr_tick)
      begin
        // Count instruction cycles
        if (remain == 7'h01)
          out <= 1'b1;
        remain <= remain - 7'h01;
      end
    end
  end
endmodule // prdly_edge_delay
`default_nettype wire

// ===== rtl/prdly_top.v
// PWM auto-restart and active-edge delay block with APB registers
// Assumes all inputs synchronous to mclk; rst covers every reset source
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "prdly_map.vh"
module prdly_top
(
  // Clock and reset
  input wire mclk,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Shutdown sources
  input wire cmp1_high,
  input wire cmp2_high,
  input wire int_pin_low,
  input wire comparator_output_sync,
  input wire first_timer_tick,
  // Scheduled PWM waveforms, pins a..d
  input wire [3:0] pwm_sched,
  // Pin drive
  output reg [3:0] pwm_out,
  output reg [3:0] pwm_oe
);
  reg restart_auto_enable; // Auto restart control
  reg [6:0] active_edge_delay_count; // Delay in instruction cycles
  reg shutdown_event_flag; // Shutdown active
  reg [2:0] shutdown_source_select; // Source code
  reg [1:0] pair_ac_shutdown_level; // Pins a and c shutdown state
  reg [1:0] pair_bd_shutdown_level; // Pins b and d shutdown state
  reg [1:0] osc_cnt; // Oscillator phase within instruction cycle
  reg cause_held; // Cause after optional timer sync
  wire instr_tick; // One pulse per four mclk
  wire raw_cause; // Decoded shutdown cause
  wire cause; // Effective cause
  wire [3:0] delayed; // Delayed waveforms
  wire wr_en; // Write strobe
  wire rd_sel; // Mapped address
  reg [31:0] next_prdata; // Read word before capture
  //
  // Timing summary for the next engineer:
  // - A write lands at the access edge, when psel and penable are high.
  // - Read data is captured at the setup edge and then stands for the
  //   whole access phase, so prdata is a flop and not a decoder output.
  //   The cost is that a status read shows the waveform one cycle late.
  // - A shutdown cause sets the event flag at the next edge, and the
  //   pins follow one edge after that.
  // - With comparator sync on, the cause only counts once the first
  //   timer tick has sampled it, so glitches that miss the tick never shut down.
  // - A rising request waits count instruction ticks; the tick phase
  //   is free running, so the delay jitters by up to three clocks.
  // - Falling requests are never delayed, so dead time only grows.
  //
  // Decode mapped register addresses
  function is_mapped;
    input [11:0] a;
    begin
      if (a == `PRDLY_OFS_DELAY_CTRL)
        is_mapped = 1'b1;
      else if (a == `PRDLY_OFS_SHUTDOWN_CTRL)
        is_mapped = 1'b1;
      else if (a == `PRDLY_OFS_STATUS)
        is_mapped = 1'b1;
      else
        is_mapped = 1'b0;
    end
  endfunction
  // Pair shutdown enable: codes 1x float both pins
  function shut_oe;
    input [1:0] code;
    begin
      shut_oe = ~code[1];
    end
  endfunction
  // Pair shutdown level: low bit picks the driven level
  function shut_lvl;
    input [1:0] code;
    begin
      shut_lvl = code[0];
    end
  endfunction
  // Zero-wait slave; unmapped gives an error
  assign pready = 1'b1;
  assign rd_sel = is_mapped(paddr);
  assign pslverr = psel & penable & ~rd_sel;
  assign wr_en = psel & penable & pwrite;
  // Instruction clock divider: mclk divided by four
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      osc_cnt <= 2'h0;
    else
      osc_cnt <= osc_cnt + 2'h1;
  end
  assign instr_tick = (osc_cnt == `PRDLY_OSC_PER_INSTR);
  // Source selection
  prdly_source_sel u_sel
  (
    .sel(shutdown_source_select),
    .cmp1_high(cmp1_high),
    .cmp2_high(cmp2_high),
    .int_pin_low(int_pin_low),
    .cause(raw_cause)
  );
  // Resample cause on first timer tick when sync is on
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      cause_held <= 1'b0;
    else if (first_timer_tick)
      cause_held <= raw_cause;
  end
  assign cause = comparator_output_sync ? cause_held : raw_cause;
  // Control registers; all reset to zero
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      restart_auto_enable <= 1'b0;
      active_edge_delay_count <= 7'h00;
      shutdown_source_select <= 3'h0;
      pair_ac_shutdown_level <= 2'h0;
      pair_bd_shutdown_level <= 2'h0;
    end
    else if (wr_en && paddr == `PRDLY_OFS_DELAY_CTRL)
    begin
      restart_auto_enable <= pwdata[`PRDLY_RESTART_BIT];
      active_edge_delay_count <= pwdata[`PRDLY_COUNT_MSB:0];
    end
    else if (wr_en && paddr == `PRDLY_OFS_SHUTDOWN_CTRL)
    begin
      shutdown_source_select <= pwdata[`PRDLY_SRC_MSB:`PRDLY_SRC_LSB];
      pair_ac_shutdown_level <= pwdata[`PRDLY_AC_MSB:`PRDLY_AC_LSB];
      pair_bd_shutdown_level <= pwdata[`PRDLY_BD_MSB:`PRDLY_BD_LSB];
    end
  end
  // Event flag; a live cause wins over any clear
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      shutdown_event_flag <= 1'b0;
    else if (cause)
      shutdown_event_flag <= 1'b1;
    else if (restart_auto_enable)
      shutdown_event_flag <= 1'b0;
    else if (wr_en && paddr == `PRDLY_OFS_SHUTDOWN_CTRL)
      shutdown_event_flag <= pwdata[`PRDLY_FLAG_BIT];
  end
  // Per-pin active-edge delay
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_dly
      prdly_edge_delay u_dly
      (
        .mclk(mclk),
        .rst(rst),
        .count(active_edge_delay_count),
        .instr_tick(instr_tick),
        .sched(pwm_sched[gi]),
        .out(delayed[gi])
      );
    end
  endgenerate
  // Output drive; shutdown state overrides waveform
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pwm_out <= 4'h0;
      pwm_oe <= 4'h0;
    end
    else if (shutdown_event_flag)
    begin
      // Pins a,c use one code, b,d the other
      pwm_out[0] <= shut_lvl(pair_ac_shutdown_level);
      pwm_out[2] <= shut_lvl(pair_ac_shutdown_level);
      pwm_oe[0] <= shut_oe(pair_ac_shutdown_level);
      pwm_oe[2] <= shut_oe(pair_ac_shutdown_level);
      pwm_out[1] <= shut_lvl(pair_bd_shutdown_level);
      pwm_out[3] <= shut_lvl(pair_bd_shutdown_level);
      pwm_oe[1] <= shut_oe(pair_bd_shutdown_level);
      pwm_oe[3] <= shut_oe(pair_bd_shutdown_level);
    end
    else
    begin
      // Normal operation
      pwm_out <= delayed;
      pwm_oe <= 4'hf;
    end
  end
  // Read word for the addressed register; unmapped reads zero
  always @*
  begin
    if (paddr == `PRDLY_OFS_DELAY_CTRL)
      next_prdata = {24'h000000, restart_auto_enable, active_edge_delay_count};
    else if (paddr == `PRDLY_OFS_SHUTDOWN_CTRL)
      next_prdata = {24'h000000, shutdown_event_flag, shutdown_source_select,
                     pair_ac_shutdown_level, pair_bd_shutdown_level};
    else if (paddr == `PRDLY_OFS_STATUS)
      next_prdata = {28'h0000000, delayed};
    else
      next_prdata = 32'h00000000;
  end
  // Capture in the setup phase; relies on paddr held through access
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      prdata <= 32'h00000000;
    else if (psel && !penable)
      prdata <= next_prdata;
  end
endmodule // prdly_top
`default_nettype wire

// ===== dv/prdly_properties.sv
// Port checker for the restart and edge-delay block
// Assumes software alone writes the control fields it mirrors
`timescale 1ns/1ns
`default_nettype none
module prdly_props
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Sources and pins
  input wire logic cmp1_high,
  input wire logic cmp2_high,
  input wire logic int_pin_low,
  input wire logic comparator_output_sync,
  input wire logic first_timer_tick,
  input wire logic [3:0] pwm_sched,
  input wire logic [3:0] pwm_out,
  input wire logic [3:0] pwm_oe
);
  logic [7:0] dc; // Delay control copy
  logic [6:0] sc; // Shutdown control copy, flag left out
  wire logic wr = psel && penable && pwrite;
  wire logic wr4 = wr && paddr == 12'h004;
  wire logic cause = |(sc[6:4] & {int_pin_low, cmp2_high, cmp1_high});
  wire logic [3:0] so = {2{!sc[1], !sc[3]}}; // Shutdown drive enables
  wire logic [3:0] sl = {2{sc[0], sc[2]}} & so; // Shutdown levels
  // Copies follow writes only; hardware also sets and clears the flag, so it is skipped
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      dc <= 8'h00;
      sc <= 7'h00;
    end
    else if (wr && paddr == 12'h000)
      dc <= pwdata[7:0];
    else if (wr4)
      sc <= pwdata[6:0];
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_cause2;
    (!comparator_output_sync && cause) [*2];
  endsequence
  property p_ready;
    psel |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_refuse;
    psel && penable && paddr > 12'h008 |-> pslverr;
  endproperty
  a_refuse: assert property (p_refuse) else $error("unmapped accepted");
  property p_rst_drive;
    $fell(rst) |=> pwm_oe == 4'hf;
  endproperty
  a_rst_drive: assert property (p_rst_drive) else $error("pins idle");
  property p_ctrl_read;
    psel && penable && !pwrite && paddr == 12'h000 |-> prdata == {24'h000000, dc};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("bad control");
  property p_shut_oe;
    s_cause2 |=> pwm_oe == so;
  endproperty
  a_shut_oe: assert property (p_shut_oe) else $error("bad enables");
  property p_shut_lvl;
    s_cause2 |=> (pwm_out & pwm_oe) == sl;
  endproperty
  a_shut_lvl: assert property (p_shut_lvl) else $error("bad levels");
  property p_auto;
    (dc[7] && !comparator_output_sync && !cause) [*3] |-> pwm_oe == 4'hf;
  endproperty
  a_auto: assert property (p_auto) else $error("no restart");
  property p_hold;
    (!dc[7] && !comparator_output_sync && cause) [*2] ##1 (!dc[7] && !wr4) [*4]
      |-> pwm_oe == so;
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
endmodule // prdly_props
bind prdly_top prdly_props u_props (.mclk, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .prdata, .pslverr, .cmp1_high, .cmp2_high, .int_pin_low,
  .comparator_output_sync, .first_timer_tick, .pwm_sched, .pwm_out, .pwm_oe);
`default_nettype wire

// ===== dv/pwm_restart_and_edge_delay_test.sv
// Bench for the restart and edge-delay block
// Assumes a zero-wait APB slave
`timescale 1ns/1ns
`default_nettype none
module pwm_restart_and_edge_delay_test;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, se;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic cmp1_high = 1'h0, cmp2_high = 1'h0, int_pin_low = 1'h0;
  logic comparator_output_sync = 1'h0, first_timer_tick = 1'h0;
  logic [3:0] pwm_sched = 4'h0, pwm_out, pwm_oe;
  wire logic pready, pslverr;
  int err_total = 0, check_count = 0, cycles = 0;
  prdly_top uut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .cmp1_high, .cmp2_high, .int_pin_low, .comparator_output_sync,
    .first_timer_tick, .pwm_sched, .pwm_out, .pwm_oe);
  always #25 mclk = ~mclk;
  // Hang guard
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 9000)
    begin
      err_total++;
      tally_and_finish;
    end
  end
  task automatic tally_and_finish;
    if (err_total == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // One APB transfer; read data and error taken at the ready edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    rd = prdata;
    se = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Rising edges wait the count in ticks of four clocks; falling ones do not
  task automatic t_delay(input int n);
    int t;
    t = 0;
    bus(1'h1, 12'h000, n);
    pwm_sched <= 4'hf;
    while (pwm_out !== 4'hf && t < 600)
    begin
      @(posedge mclk);
      t++;
    end
    chk(t + 2 >= 4 * n && t <= 4 * n + 4, 1'h1);
    bus(1'h0, 12'h008, 32'h0);
    chk(rd, 32'hf);
    pwm_sched <= 4'h0;
    tk(3);
    chk(pwm_out, 4'h0);
  endtask
  // Each code against each single source, auto restart on
  task automatic t_sources;
    bus(1'h1, 12'h000, 32'h80);
    pwm_sched <= 4'hf;
    for (int s = 0; s < 8; s++)
      for (int k = 0; k < 3; k++)
      begin
        bus(1'h1, 12'h004, s << 4);
        {int_pin_low, cmp2_high, cmp1_high} <= 3'h1 << k;
        tk(4);
        chk(pwm_out, s[k] ? 4'h0 : 4'hf);
        {int_pin_low, cmp2_high, cmp1_high} <= 3'h0;
        tk(4);
        chk(pwm_out, 4'hf);
      end
  endtask
  // Synchronised cause waits for the timer tick
  task automatic t_sync;
    bus(1'h1, 12'h004, 32'h10);
    comparator_output_sync <= 1'h1;
    cmp1_high <= 1'h1;
    tk(6);
    chk(pwm_out, 4'hf);
    first_timer_tick <= 1'h1;
    tk(1);
    first_timer_tick <= 1'h0;
    tk(3);
    chk(pwm_out, 4'h0);
    cmp1_high <= 1'h0;
    comparator_output_sync <= 1'h0;
  endtask
  // Without auto restart the flag stays until software clears it
  task automatic t_manual;
    bus(1'h1, 12'h000, 32'h0);
    bus(1'h1, 12'h004, 32'h17);
    cmp1_high <= 1'h1;
    tk(4);
    chk({pwm_oe, pwm_out & pwm_oe}, 8'h55);
    cmp1_high <= 1'h0;
    tk(6);
    bus(1'h0, 12'h004, 32'h0);
    chk(rd, 32'h97);
    bus(1'h1, 12'h004, 32'h17);
    tk(3);
    chk(pwm_oe, 4'hf);
  endtask
  initial
  begin
    tk(20);
    rst <= 1'h0;
    bus(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    bus(1'h0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    bus(1'h0, 12'h00c, 32'h0);
    chk(se, 1'h1);
    t_delay(0);
    t_delay(3);
    t_delay(127);
    t_sources;
    t_sync;
    t_manual;
    tally_and_finish;
  end
endmodule // pwm_restart_and_edge_delay_test
`default_nettype wire
